// *** shared/ptach_regs.vh ***
// constants of the prescaled tachometer counter
`ifndef PTACH_REGS_VH
`define PTACH_REGS_VH
`define PTACH_CLK_HZ       32'h02FA_F080
`define PTACH_GATE_S       32'h0000_0001
`define PTACH_GATE_CYCLES  (`PTACH_CLK_HZ * `PTACH_GATE_S)
`define PTACH_READ_MAX     14'h2710
`define PTACH_W_HUND       10'h064
`define PTACH_W_TENS       10'h00A
`define PTACH_MODE_DIV     1'h0
`define PTACH_MODE_MUL     1'h1
`define PTACH_CNT_W        32
`define PTACH_RESET_READ   14'h0000
`endif

// *** src/ptach_scale.v ***
// scaling unit: divide or multiply a gate count by the prescale factor, saturated
`timescale 1ns/10ps
`default_nettype none
`include "ptach_regs.vh"
module ptach_scale (
  // operands
  input  wire [31:0] count,
  input  wire [9:0]  factor,
  input  wire        mode_mul,
  // result
  output reg  [13:0] result
);
  reg [41:0] prod;
  reg [31:0] quot;
  always @* begin
    prod = 42'h0;
    quot = 32'h0;
    result = `PTACH_RESET_READ;
    if (mode_mul == `PTACH_MODE_MUL) begin
      prod = count * factor;
      if (prod > {28'h0, `PTACH_READ_MAX})
        result = `PTACH_READ_MAX;
      else
        result = prod[13:0];
    end else begin
      // zero factor treated as one
      quot = (factor == 10'h000) ? count : count / {22'h0, factor};
      if (quot > {18'h0, `PTACH_READ_MAX})
        result = `PTACH_READ_MAX;
      else
        result = quot[13:0];
    end
  end
endmodule // ptach_scale
`default_nettype wire

// *** src/ptach_top.v ***
// prescaled tachometer counter: gate, pulse count, scale and reading latch

`timescale 1ns/10ps
`default_nettype none
`include "ptach_regs.vh"

module ptach_top #(
  parameter [31:0] GATE_CYCLES = `PTACH_GATE_CYCLES
) (
  // clock and reset
  input  wire        clk,
  input  wire        reset,
  // encoder pulse pin
  input  wire        enc_pulse,
  // prescale selectors
  input  wire        sel_multiply,
  input  wire [3:0]  sel_hund,
  input  wire [3:0]  sel_tens,
  input  wire [3:0]  sel_units,
  // reading
  output reg  [13:0] reading,
  output reg         reading_valid
);

  // ----------------------------------------------------------------
  // pin gathering
  // ----------------------------------------------------------------
  localparam PIN_W    = 14;
  localparam PIN_ENC  = 13;
  localparam PIN_MODE = 12;

  wire [13:0] pin_raw;
  wire [13:0] pin_sync;

  assign pin_raw[PIN_ENC]  = enc_pulse;
  assign pin_raw[PIN_MODE] = sel_multiply;
  assign pin_raw[11:8]     = sel_hund;
  assign pin_raw[7:4]      = sel_tens;
  assign pin_raw[3:0]      = sel_units;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // every pin is asynchronous, so each bit passes two flops
  genvar gi;

  generate
    for (gi = 0; gi < PIN_W; gi = gi + 1) begin : g_sync
      reg stage1;
      reg stage2;

      always @(posedge clk) begin
        if (reset) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end else begin
          stage1 <= pin_raw[gi];
          stage2 <= stage1;
        end
      end

      assign pin_sync[gi] = stage2;
    end
  endgenerate

  // ----------------------------------------------------------------
  // synchronised fields
  // ----------------------------------------------------------------
  wire       pulse_sync;
  wire       mode_mul;
  wire [3:0] digit_hund;
  wire [3:0] digit_tens;
  wire [3:0] digit_units;

  assign pulse_sync  = pin_sync[PIN_ENC];
  assign mode_mul    = pin_sync[PIN_MODE];
  assign digit_hund  = pin_sync[11:8];
  assign digit_tens  = pin_sync[7:4];
  assign digit_units = pin_sync[3:0];

  // ----------------------------------------------------------------
  // encoder edge detector
  // ----------------------------------------------------------------
  reg  pulse_d;
  wire pulse_rise;

  // resets low like the idle pin, so no false edge follows reset
  always @(posedge clk) begin
    if (reset) begin
      pulse_d <= 1'b0;
    end else begin
      pulse_d <= pulse_sync;
    end
  end

  assign pulse_rise = pulse_sync & ~pulse_d;

  // ----------------------------------------------------------------
  // prescale factor
  // ----------------------------------------------------------------
  wire [9:0] weight_hund;
  wire [9:0] weight_tens;
  wire [9:0] weight_units;
  wire [9:0] factor;

  assign weight_hund  = {6'h00, digit_hund} * `PTACH_W_HUND;
  assign weight_tens  = {6'h00, digit_tens} * `PTACH_W_TENS;
  assign weight_units = {6'h00, digit_units};
  // largest legal setting is 999, which fits ten bits
  assign factor       = weight_hund + weight_tens + weight_units;

  // ----------------------------------------------------------------
  // gate timer
  // ----------------------------------------------------------------
  // index of the closing cycle of each gate
  localparam [31:0] GATE_LAST = GATE_CYCLES - 32'h0000_0001;

  reg  [31:0] gate_cnt;
  reg  [31:0] next_gate_cnt;
  wire        gate_end;

  assign gate_end = (gate_cnt == GATE_LAST);

  always @* begin
    next_gate_cnt = gate_cnt + 32'h0000_0001;
    if (gate_end) begin
      next_gate_cnt = 32'h0000_0000;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      gate_cnt <= 32'h0000_0000;
    end else begin
      gate_cnt <= next_gate_cnt;
    end
  end

  // ----------------------------------------------------------------
  // pulse counter
  // ----------------------------------------------------------------
  reg  [31:0] pulse_cnt;
  reg  [31:0] next_pulse_cnt;
  wire        pulse_full;
  wire        pulse_step;

  // saturates rather than wrapping, so a flood still reads as the cap
  assign pulse_full = (pulse_cnt == 32'hFFFF_FFFF);
  assign pulse_step = pulse_rise & ~pulse_full;

  always @* begin
    next_pulse_cnt = pulse_cnt;
    if (gate_end) begin
      // an edge on the closing cycle belongs to the new gate
      next_pulse_cnt = {31'h0, pulse_rise};
    end else if (pulse_step) begin
      next_pulse_cnt = pulse_cnt + 32'h0000_0001;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      pulse_cnt <= 32'h0000_0000;
    end else begin
      pulse_cnt <= next_pulse_cnt;
    end
  end

  // ----------------------------------------------------------------
  // scaling
  // ----------------------------------------------------------------
  wire [13:0] scaled;

  ptach_scale u_scale (
    .count    (pulse_cnt),
    .factor   (factor),
    .mode_mul (mode_mul),
    .result   (scaled)
  );

  // ----------------------------------------------------------------
  // reading latch
  // ----------------------------------------------------------------
  reg [13:0] next_reading;
  reg        next_reading_valid;

  always @* begin
    next_reading       = reading;
    next_reading_valid = 1'b0;
    if (gate_end) begin
      next_reading       = scaled;
      next_reading_valid = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      reading       <= `PTACH_RESET_READ;
      reading_valid <= 1'b0;
    end else begin
      reading       <= next_reading;
      reading_valid <= next_reading_valid;
    end
  end

endmodule // ptach_top
`default_nettype wire

// *** test/ptach_checker.sv ***
// checker of the tachometer reading port timing
`timescale 1ns/10ps
`default_nettype none
module ptach_checker #(parameter [31:0] GATE_CYCLES = 100) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [13:0] reading,
  input wire logic        reading_valid
);
  int gap;
  bit seen;
  // cycles since the previous reading update
  always @(posedge clk)
    if (reset) begin gap <= 0; seen <= 0; end
    else if (reading_valid) begin gap <= 1; seen <= 1; end
    else gap <= gap + 1;
  property p_period;
    @(posedge clk) disable iff (reset) reading_valid && seen |-> gap == GATE_CYCLES;
  endproperty
  a_period: assert property (p_period) else $error("gate length wrong");
  sequence s_update;
    reading_valid ##1 !reading_valid;
  endsequence
  property p_pulse;
    @(posedge clk) disable iff (reset) reading_valid |-> s_update;
  endproperty
  a_pulse: assert property (p_pulse) else $error("valid too long");
  property p_cap;
    @(posedge clk) disable iff (reset) reading <= 14'h2710;
  endproperty
  a_cap: assert property (p_cap) else $error("reading above cap");
  property p_hold;
    @(posedge clk) disable iff (reset) !reading_valid |-> $stable(reading);
  endproperty
  a_hold: assert property (p_hold) else $error("reading moved");
  property p_clear;
    @(posedge clk) disable iff (reset) $past(reset) |-> reading == 14'h0000 && !reading_valid;
  endproperty
  a_clear: assert property (p_clear) else $error("reset value wrong");
  property p_reset;
    @(posedge clk) reset |=> reading == 14'h0000 && !reading_valid;
  endproperty
  a_reset: assert property (p_reset) else $error("reset not honoured");
endmodule // ptach_checker
bind ptach_top ptach_checker #(.GATE_CYCLES(GATE_CYCLES)) chk_u (.clk(clk), .reset(reset),
  .reading(reading), .reading_valid(reading_valid));
`default_nettype wire

// *** test/ptach_encoder.sv ***
// encoder model: n pulses, two cycles high and two low, after go
`timescale 1ns/10ps
`default_nettype none
module ptach_encoder (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [4:0] n,
  output wire logic       pulse
);
  logic [6:0] ph = 7'h00;
  always @(posedge clk) ph <= go ? {n, 2'h0} : (ph != 7'h00 ? ph - 7'h01 : ph);
  assign pulse = ph[1];
endmodule // ptach_encoder
`default_nettype wire

// *** test/ptach_top_test.sv ***
// self-checking bench of the prescaled tachometer counter
`timescale 1ns/10ps
`default_nettype none
module ptach_top_test;
  logic clk = 0, reset = 1, go = 0, mul = 0, valid, pulse;
  logic [11:0] sel = 12'h000;
  logic [4:0] n = 5'h00;
  logic [13:0] rd;
  int n_fail = 0, checks = 0, i;
  // mode, bcd factor, pulses, expected reading
  logic [31:0] rows [11] = '{{1'h0,12'h001,5'h11,14'h0011}, {1'h0,12'h003,5'h14,14'h0006},
    {1'h1,12'h012,5'h05,14'h003C}, {1'h1,12'h100,5'h07,14'h02BC}, {1'h1,12'h020,5'h0F,14'h012C},
    {1'h1,12'h999,5'h14,14'h2710}, {1'h1,12'h500,5'h14,14'h2710}, {1'h0,12'h123,5'h14,14'h0000},
    {1'h0,12'h010,5'h13,14'h0001}, {1'h0,12'h000,5'h07,14'h0007}, {1'h1,12'h000,5'h07,14'h0000}};
  always #10 clk = ~clk;
  ptach_encoder enc_u (.clk(clk), .go(go), .n(n), .pulse(pulse));
  ptach_top #(.GATE_CYCLES(100)) dut_u (.clk(clk), .reset(reset), .enc_pulse(pulse),
    .sel_multiply(mul), .sel_hund(sel[11:8]), .sel_tens(sel[7:4]), .sel_units(sel[3:0]),
    .reading(rd), .reading_valid(valid));
  task tally_and_finish;
    if (n_fail == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task cmp_read(input logic [13:0] exp);
    checks++;
    if (rd !== exp) begin n_fail++; $display("[ERR] %0t reading %h not %h", $time, rd, exp); end
  endtask
  task wait_valid;
    int k;
    for (k = 0; k < 200 && valid !== 1'b1; k++) @(negedge clk);
    if (k == 200) begin n_fail++; $display("[ERR] %0t no reading", $time); tally_and_finish; end
  endtask
  initial begin
    repeat (3) @(negedge clk);
    reset = 0;
    wait_valid;
    cmp_read(14'h0000);
    for (i = 0; i < 11; i++) begin
      {mul, sel, n} = rows[i][31:14];
      go = 1;
      @(negedge clk);
      go = 0;
      wait_valid;
      cmp_read(rows[i][13:0]);
    end
    reset = 1;
    @(negedge clk);
    reset = 0;
    cmp_read(14'h0000);
    tally_and_finish;
  end
endmodule // ptach_top_test
`default_nettype wire
